// File: src/bru_cfg.svh
// Overview of operation
// - rotate_left_to_acc: byte left one, bit 7 to bit 0, into accumulator only.
// - rotate_left_via_carry: left one, old carry to bit 0, bit 7 to carry, memory.
// - rotate_left_via_carry_to_acc: same nine-bit rotation, result to accumulator, carry updated.
// - rotate_right_in_place: right one, bit 0 to bit 7, back to memory, no flags.
// - rotate_right_to_acc: right one, bit 0 to bit 7, into accumulator, no flags.
// - rotate_right_via_carry: right one, old carry to bit 7, bit 0 to carry, memory.
`ifndef BRU_CFG_SVH
`define BRU_CFG_SVH

// ****************************************
// data layout
// ****************************************
`define BRU_DATA_W 8
`define BRU_MSB 7
`define BRU_LSB 0
`define BRU_ZERO_BYTE 8'h00

// ****************************************
// operation codes
// ****************************************
`define BRU_OP_W 3
`define BRU_OP_ROT_L_ACC 3'h0
`define BRU_OP_ROT_L_C 3'h1
`define BRU_OP_ROT_L_C_ACC 3'h2
`define BRU_OP_ROT_R_MEM 3'h3
`define BRU_OP_ROT_R_ACC 3'h4
`define BRU_OP_ROT_R_C 3'h5
`define BRU_OP_LAST_LEGAL 3'h5

// ****************************************
// sequencer state codes
// ****************************************
`define BRU_ST_IDLE_CODE 2'b01
`define BRU_ST_WRITE_CODE 2'b10

`endif

// File: src/bru_pkg.sv
`include "bru_cfg.svh"

package bru_pkg;

  // ****************************************
  // operation and state types
  // ****************************************
  typedef enum logic [`BRU_OP_W-1:0] {
    bru_rotate_left_to_acc = `BRU_OP_ROT_L_ACC,
    bru_rotate_left_via_carry = `BRU_OP_ROT_L_C,
    bru_rotate_left_via_carry_to_acc = `BRU_OP_ROT_L_C_ACC,
    bru_rotate_right_in_place = `BRU_OP_ROT_R_MEM,
    bru_rotate_right_to_acc = `BRU_OP_ROT_R_ACC,
    bru_rotate_right_via_carry = `BRU_OP_ROT_R_C
  } bru_op_e;

  typedef enum logic [1:0] {
    bru_st_idle = `BRU_ST_IDLE_CODE,
    bru_st_write = `BRU_ST_WRITE_CODE
  } bru_state_e;

  typedef logic [`BRU_DATA_W-1:0] bru_byte_t;

  // ****************************************
  // top state record
  // ****************************************
  typedef struct packed {
    bru_state_e state;
    logic ready;
    bru_byte_t result;
    logic mem_we;
    logic acc_we;
    logic carry_we;
    logic carry_val;
    logic done;
    logic illegal;
  } bru_top_s;

  typedef struct packed {
    logic unused;
  } bru_rot_s;

endpackage

// File: src/bru_rot_if.sv
`timescale 1ns/1ps
`include "bru_cfg.svh"

interface bru_rot_if;
  bru_pkg::bru_op_e op;
  logic legal;
  bru_pkg::bru_byte_t operand;
  logic carry_old;
  bru_pkg::bru_byte_t result;
  logic carry_new;
  logic to_mem;
  logic to_acc;
  logic uses_carry;

  modport calc (
    input op,
    input legal,
    input operand,
    input carry_old,
    output result,
    output carry_new,
    output to_mem,
    output to_acc,
    output uses_carry
  );

  modport ctrl (
    output op,
    output legal,
    output operand,
    output carry_old,
    input result,
    input carry_new,
    input to_mem,
    input to_acc,
    input uses_carry
  );
endinterface

// File: src/bru_rotator.sv
`timescale 1ns/1ps
`include "bru_cfg.svh"

module bru_rotator (
  bru_rot_if.calc rot
);

  // ****************************************
  // rotation helpers
  // ****************************************
  function automatic bru_pkg::bru_byte_t bru_rol(input bru_pkg::bru_byte_t v, input logic fill);
    bru_rol = {v[`BRU_MSB-1:`BRU_LSB], fill};
  endfunction

  function automatic bru_pkg::bru_byte_t bru_ror(input bru_pkg::bru_byte_t v, input logic fill);
    bru_ror = {fill, v[`BRU_MSB:`BRU_LSB+1]};
  endfunction

  // ****************************************
  // datapath
  // ****************************************
  always_comb begin
    rot.result = `BRU_ZERO_BYTE;
    rot.carry_new = rot.carry_old;
    rot.to_mem = 1'b0;
    rot.to_acc = 1'b0;
    rot.uses_carry = 1'b0;
    if (rot.legal) begin
      case (rot.op)
        bru_pkg::bru_rotate_left_to_acc: begin
          rot.result = bru_rol(rot.operand, rot.operand[`BRU_MSB]);
          rot.to_acc = 1'b1;
        end
        bru_pkg::bru_rotate_left_via_carry: begin
          rot.result = bru_rol(rot.operand, rot.carry_old);
          rot.carry_new = rot.operand[`BRU_MSB];
          rot.to_mem = 1'b1;
          rot.uses_carry = 1'b1;
        end
        bru_pkg::bru_rotate_left_via_carry_to_acc: begin
          rot.result = bru_rol(rot.operand, rot.carry_old);
          rot.carry_new = rot.operand[`BRU_MSB];
          rot.to_acc = 1'b1;
          rot.uses_carry = 1'b1;
        end
        bru_pkg::bru_rotate_right_in_place: begin
          rot.result = bru_ror(rot.operand, rot.operand[`BRU_LSB]);
          rot.to_mem = 1'b1;
        end
        bru_pkg::bru_rotate_right_to_acc: begin
          rot.result = bru_ror(rot.operand, rot.operand[`BRU_LSB]);
          rot.to_acc = 1'b1;
        end
        bru_pkg::bru_rotate_right_via_carry: begin
          rot.result = bru_ror(rot.operand, rot.carry_old);
          rot.carry_new = rot.operand[`BRU_LSB];
          rot.to_mem = 1'b1;
          rot.uses_carry = 1'b1;
        end
        default: begin
          rot.result = `BRU_ZERO_BYTE;
        end
      endcase
    end
  end

endmodule

// File: src/bru_top.sv
`timescale 1ns/1ps
`include "bru_cfg.svh"

module bru_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic op_valid,
  input wire logic [`BRU_OP_W-1:0] op_code,
  input wire logic [`BRU_DATA_W-1:0] mem_data,
  input wire logic carry_flag,
  output logic op_ready,
  output logic [`BRU_DATA_W-1:0] result_data,
  output logic mem_write,
  output logic acc_write,
  output logic carry_write,
  output logic carry_value,
  output logic op_done,
  output logic op_illegal
);

  // ****************************************
  // datapath connection
  // ****************************************
  bru_rot_if rot ();

  bru_rotator bru_rotator_i (
    .rot(rot.calc)
  );

  bru_pkg::bru_top_s st_reg;
  bru_pkg::bru_top_s st_next;
  logic take;

  assign take = op_valid && st_reg.ready;
  assign rot.op = bru_pkg::bru_op_e'(op_code);
  assign rot.legal = (op_code <= `BRU_OP_LAST_LEGAL);
  assign rot.operand = mem_data;
  assign rot.carry_old = carry_flag;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.mem_we = 1'b0;
    st_next.acc_we = 1'b0;
    st_next.carry_we = 1'b0;
    st_next.done = 1'b0;
    st_next.illegal = 1'b0;
    case (st_reg.state)
      bru_pkg::bru_st_idle: begin
        if (take) begin
          st_next.state = bru_pkg::bru_st_write;
          st_next.ready = 1'b0;
          st_next.result = rot.result;
          st_next.mem_we = rot.to_mem;
          st_next.acc_we = rot.to_acc;
          st_next.carry_we = rot.uses_carry;
          st_next.carry_val = rot.carry_new;
          st_next.done = 1'b1;
          st_next.illegal = !rot.legal;
        end
      end
      bru_pkg::bru_st_write: begin
        st_next.state = bru_pkg::bru_st_idle;
        st_next.ready = 1'b1;
      end
      default: begin
        st_next.state = bru_pkg::bru_st_idle;
        st_next.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_reg.state <= bru_pkg::bru_st_idle;
      st_reg.ready <= 1'b1;
      st_reg.result <= `BRU_ZERO_BYTE;
      st_reg.mem_we <= 1'b0;
      st_reg.acc_we <= 1'b0;
      st_reg.carry_we <= 1'b0;
      st_reg.carry_val <= 1'b0;
      st_reg.done <= 1'b0;
      st_reg.illegal <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign op_ready = st_reg.ready;
  assign result_data = st_reg.result;
  assign mem_write = st_reg.mem_we;
  assign acc_write = st_reg.acc_we;
  assign carry_write = st_reg.carry_we;
  assign carry_value = st_reg.carry_val;
  assign op_done = st_reg.done;
  assign op_illegal = st_reg.illegal;

  // ****************************************
  // checks
  // ****************************************
  logic chk_take;
  logic [`BRU_OP_W-1:0] chk_op;
  logic [`BRU_DATA_W-1:0] chk_data;
  logic chk_carry;

  always_ff @(posedge clock) begin
    if (reset) begin
      chk_take <= 1'b0;
      chk_op <= `BRU_OP_ROT_L_ACC;
      chk_data <= `BRU_ZERO_BYTE;
      chk_carry <= 1'b0;
    end else begin
      chk_take <= take;
      chk_op <= op_code;
      chk_data <= mem_data;
      chk_carry <= carry_flag;
    end
  end

  a_rol_acc_result: assert property (@(posedge clock) disable iff (reset)
    (chk_take && chk_op == `BRU_OP_ROT_L_ACC) |-> (acc_write && !mem_write && !carry_write
      && result_data == {chk_data[`BRU_MSB-1:`BRU_LSB], chk_data[`BRU_MSB]}))
    else $error("rotate left to accumulator wrong");

  a_rol_carry_mem: assert property (@(posedge clock) disable iff (reset)
    (chk_take && chk_op == `BRU_OP_ROT_L_C) |-> (mem_write && !acc_write && carry_write
      && carry_value == chk_data[`BRU_MSB] && result_data == {chk_data[`BRU_MSB-1:`BRU_LSB], chk_carry}))
    else $error("rotate left via carry wrong");

  a_rol_carry_acc: assert property (@(posedge clock) disable iff (reset)
    (chk_take && chk_op == `BRU_OP_ROT_L_C_ACC) |-> (acc_write && !mem_write && carry_write
      && carry_value == chk_data[`BRU_MSB] && result_data == {chk_data[`BRU_MSB-1:`BRU_LSB], chk_carry}))
    else $error("rotate left via carry to accumulator wrong");

  a_ror_mem_result: assert property (@(posedge clock) disable iff (reset)
    (chk_take && chk_op == `BRU_OP_ROT_R_MEM) |-> (mem_write && !acc_write && !carry_write
      && result_data == {chk_data[`BRU_LSB], chk_data[`BRU_MSB:`BRU_LSB+1]}))
    else $error("rotate right in place wrong");

  a_ror_acc_result: assert property (@(posedge clock) disable iff (reset)
    (chk_take && chk_op == `BRU_OP_ROT_R_ACC) |-> (acc_write && !mem_write && !carry_write
      && result_data == {chk_data[`BRU_LSB], chk_data[`BRU_MSB:`BRU_LSB+1]}))
    else $error("rotate right to accumulator wrong");

  a_ror_carry_mem: assert property (@(posedge clock) disable iff (reset)
    (chk_take && chk_op == `BRU_OP_ROT_R_C) |-> (mem_write && !acc_write && carry_write
      && carry_value == chk_data[`BRU_LSB] && result_data == {chk_carry, chk_data[`BRU_MSB:`BRU_LSB+1]}))
    else $error("rotate right via carry wrong");

  a_carry_with_dest: assert property (@(posedge clock) disable iff (reset)
    carry_write |-> (op_done && (mem_write ^ acc_write)))
    else $error("carry written apart from destination");

  a_write_one_cycle: assert property (@(posedge clock) disable iff (reset)
    (op_valid && op_ready) |=> (op_done && !op_ready) ##1 (!op_done && !mem_write && !acc_write
      && !carry_write && op_ready))
    else $error("write strobes not single cycle");

  // ****************************************
  // strobe and hold checks
  // ****************************************
  a_illegal_no_write: assert property (@(posedge clock) disable iff (reset)
    (chk_take && chk_op > `BRU_OP_LAST_LEGAL) |-> (op_done && op_illegal && !mem_write && !acc_write
      && !carry_write && result_data == `BRU_ZERO_BYTE))
    else $error("illegal code not refused");

  a_legal_one_dest: assert property (@(posedge clock) disable iff (reset)
    (chk_take && chk_op <= `BRU_OP_LAST_LEGAL) |-> (op_done && !op_illegal && (mem_write ^ acc_write)))
    else $error("legal code without single destination");

  a_done_needs_take: assert property (@(posedge clock) disable iff (reset)
    op_done |-> chk_take)
    else $error("done without a taken request");

  a_busy_refuses: assert property (@(posedge clock) disable iff (reset)
    !op_ready |=> (op_ready && !op_done))
    else $error("request taken while busy");

  a_result_holds: assert property (@(posedge clock) disable iff (reset)
    (!chk_take && !$past(reset)) |-> ($stable(result_data) && $stable(carry_value)))
    else $error("result changed without a request");

  a_ready_after_done: assert property (@(posedge clock) disable iff (reset)
    op_done |=> (op_ready && !op_done))
    else $error("not ready after done");

  a_carry_ops_only: assert property (@(posedge clock) disable iff (reset)
    carry_write |-> (chk_take && (chk_op == `BRU_OP_ROT_L_C || chk_op == `BRU_OP_ROT_L_C_ACC
      || chk_op == `BRU_OP_ROT_R_C)))
    else $error("carry written by a plain rotation");

  a_mem_write_ops: assert property (@(posedge clock) disable iff (reset)
    mem_write |-> (chk_take && (chk_op == `BRU_OP_ROT_L_C || chk_op == `BRU_OP_ROT_R_MEM
      || chk_op == `BRU_OP_ROT_R_C)))
    else $error("memory written by an accumulator form");

  a_acc_write_ops: assert property (@(posedge clock) disable iff (reset)
    acc_write |-> (chk_take && (chk_op == `BRU_OP_ROT_L_ACC || chk_op == `BRU_OP_ROT_L_C_ACC
      || chk_op == `BRU_OP_ROT_R_ACC)))
    else $error("accumulator written by an in-place form");

  a_idle_quiet: assert property (@(posedge clock) disable iff (reset)
    op_ready |-> (!op_done && !op_illegal && !mem_write && !acc_write && !carry_write))
    else $error("strobe while idle");

  a_illegal_with_done: assert property (@(posedge clock) disable iff (reset)
    op_illegal |-> (op_done && !mem_write && !acc_write && !carry_write))
    else $error("illegal flag without done");

  a_one_dest_pulse: assert property (@(posedge clock) disable iff (reset)
    !(mem_write && acc_write))
    else $error("memory and accumulator written together");

  a_reset_values: assert property (@(posedge clock) disable iff (reset)
    $past(reset) |-> (op_ready && !op_done && result_data == `BRU_ZERO_BYTE && !carry_value))
    else $error("outputs not cleared by reset");

endmodule

// File: testbench/bru_core_model.sv
`timescale 1ns/1ps
`include "bru_cfg.svh"

// ****************************************
// core side: memory byte, accumulator, carry
// ****************************************
module bru_core_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic preload,
  input wire logic [`BRU_DATA_W-1:0] preload_mem,
  input wire logic preload_carry,
  input wire logic [`BRU_DATA_W-1:0] result_data,
  input wire logic mem_write,
  input wire logic acc_write,
  input wire logic carry_write,
  input wire logic carry_value,
  output logic [`BRU_DATA_W-1:0] mem_reg,
  output logic [`BRU_DATA_W-1:0] acc_reg,
  output logic carry_reg
);
  always_ff @(posedge clock) begin
    if (reset || preload) begin
      mem_reg <= preload_mem;
      acc_reg <= 8'h5a;
      carry_reg <= preload_carry;
    end else begin
      if (mem_write) begin
        mem_reg <= result_data;
      end
      if (acc_write) begin
        acc_reg <= result_data;
      end
      if (carry_write) begin
        carry_reg <= carry_value;
      end
    end
  end
endmodule

// File: testbench/bru_top_tb_top.sv
`timescale 1ns/1ps
`include "bru_cfg.svh"

module bru_top_tb_top;
  logic clock, reset, op_valid, carry_flag, op_ready, mem_write, acc_write;
  logic carry_write, carry_value, op_done, op_illegal, preload, preload_carry;
  logic [`BRU_OP_W-1:0] op_code;
  logic [`BRU_DATA_W-1:0] mem_data, result_data, acc_reg, preload_mem;
  int num_errors, num_checks;

  // ****************************************
  // design and core model
  // ****************************************
  bru_top bru_top_i (.clock(clock), .reset(reset), .op_valid(op_valid), .op_code(op_code),
    .mem_data(mem_data), .carry_flag(carry_flag), .op_ready(op_ready), .result_data(result_data),
    .mem_write(mem_write), .acc_write(acc_write), .carry_write(carry_write),
    .carry_value(carry_value), .op_done(op_done), .op_illegal(op_illegal));
  bru_core_model bru_core_model_i (.clock(clock), .reset(reset), .preload(preload),
    .preload_mem(preload_mem), .preload_carry(preload_carry), .result_data(result_data),
    .mem_write(mem_write), .acc_write(acc_write), .carry_write(carry_write),
    .carry_value(carry_value), .mem_reg(mem_data), .acc_reg(acc_reg), .carry_reg(carry_flag));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one transfer: preload core, request, check pulses, then core state
  task automatic run_op(input logic [2:0] code, input logic [7:0] m, input logic c, input logic [3:0] pulses,
                        input logic [7:0] em, input logic [7:0] ea, input logic ec);
    int n;
    n = 0;
    while (op_ready !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    if (op_ready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    preload = 1'b1;
    preload_mem = m;
    preload_carry = c;
    tick();
    preload = 1'b0;
    op_valid = 1'b1;
    op_code = code;
    tick();
    op_valid = 1'b0;
    check_byte({op_done, op_ready, op_illegal}, 8'h04 | {7'h00, pulses[3]});
    check_byte({mem_write, acc_write, carry_write}, {5'h00, pulses[2:0]});
    tick();
    check_byte({op_done, op_ready, mem_write, acc_write, carry_write}, 8'h08);
    check_byte(mem_data, em);
    check_byte(acc_reg, ea);
    check_byte(carry_flag, ec);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset;
    check_byte({op_ready, op_done, mem_write, acc_write, carry_write, op_illegal}, 8'h20);
    check_byte(result_data, 8'h00);
    check_byte(carry_value, 8'h00);
  endtask

  task automatic test_left_acc;
    run_op(`BRU_OP_ROT_L_ACC, 8'h81, 1'b1, 4'h2, 8'h81, 8'h03, 1'b1);
  endtask

  task automatic test_left_carry;
    run_op(`BRU_OP_ROT_L_C, 8'h81, 1'b0, 4'h5, 8'h02, 8'h5a, 1'b1);
    run_op(`BRU_OP_ROT_L_C, 8'h40, 1'b1, 4'h5, 8'h81, 8'h5a, 1'b0);
  endtask

  task automatic test_left_carry_acc;
    run_op(`BRU_OP_ROT_L_C_ACC, 8'h7e, 1'b1, 4'h3, 8'h7e, 8'hfd, 1'b0);
  endtask

  task automatic test_right_mem;
    run_op(`BRU_OP_ROT_R_MEM, 8'h01, 1'b0, 4'h4, 8'h80, 8'h5a, 1'b0);
  endtask

  task automatic test_right_acc;
    run_op(`BRU_OP_ROT_R_ACC, 8'h02, 1'b1, 4'h2, 8'h02, 8'h01, 1'b1);
  endtask

  task automatic test_right_carry;
    run_op(`BRU_OP_ROT_R_C, 8'h01, 1'b0, 4'h5, 8'h00, 8'h5a, 1'b1);
    run_op(`BRU_OP_ROT_R_C, 8'h80, 1'b1, 4'h5, 8'hc0, 8'h5a, 1'b0);
  endtask

  task automatic test_illegal;
    run_op(3'h6, 8'h33, 1'b1, 4'h8, 8'h33, 8'h5a, 1'b1);
    check_byte(result_data, 8'h00);
    run_op(3'h7, 8'hcc, 1'b0, 4'h8, 8'hcc, 8'h5a, 1'b0);
  endtask

  // request held through the busy cycle leaves no trace
  task automatic test_refused;
    preload = 1'b1;
    preload_mem = 8'h11;
    preload_carry = 1'b0;
    tick();
    preload = 1'b0;
    op_valid = 1'b1;
    op_code = `BRU_OP_ROT_R_MEM;
    tick();
    op_code = `BRU_OP_ROT_L_ACC;
    check_byte({op_ready, mem_write}, 8'h01);
    tick();
    op_valid = 1'b0;
    check_byte({op_done, acc_write, op_ready}, 8'h01);
    tick();
    check_byte({op_done, acc_write}, 8'h00);
    check_byte(mem_data, 8'h88);
    check_byte(acc_reg, 8'h5a);
  endtask

  // reset in the busy cycle cuts the transfer; first request follows one preload cycle after release
  task automatic test_mid_reset;
    op_valid = 1'b1;
    op_code = `BRU_OP_ROT_L_C;
    tick();
    op_valid = 1'b0;
    reset = 1'b1;
    tick();
    reset = 1'b0;
    check_byte({op_ready, op_done, mem_write, acc_write, carry_write, op_illegal}, 8'h20);
    check_byte(result_data, 8'h00);
    check_byte(carry_value, 8'h00);
    run_op(`BRU_OP_ROT_R_ACC, 8'hf0, 1'b0, 4'h2, 8'hf0, 8'h78, 1'b0);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    num_errors = 0;
    num_checks = 0;
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = 3'h0;
    preload = 1'b0;
    preload_mem = 8'h00;
    preload_carry = 1'b0;
    tick();
    tick();
    test_reset();
    reset = 1'b0;
    test_left_acc();
    test_left_carry();
    test_left_carry_acc();
    test_right_mem();
    test_right_acc();
    test_right_carry();
    test_illegal();
    test_refused();
    test_mid_reset();
    give_verdict();
  end

  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
endmodule
